// ==== rtl/pin_sync.sv ====
// Two-stage synchroniser for a group of asynchronous pin inputs
`timescale 1ns/100ps
module pin_sync #(
    parameter int WIDTH = 1
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic [WIDTH-1:0] din,
    output logic [WIDTH-1:0] dout
);
    logic [WIDTH-1:0] stage_reg;
    logic [WIDTH-1:0] stage_next;
    logic [WIDTH-1:0] dout_next;

    // First stage feeds only the second stage
    always_comb begin
        stage_next = din;
        dout_next = stage_reg;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            stage_reg <= '0;
            dout <= '0;
        end else if (ce) begin
            stage_reg <= stage_next;
            dout <= dout_next;
        end
    end
endmodule : pin_sync

// ==== rtl/virtual_phy_basic_control.sv ====
// Virtual PHY basic control register with memory-mapped and serial management access
//
// Contract
// - Writing bit 15 restores every register default; bit self-clears.
// - Loader contents overwrite the whole control word after any reset or reload.
// - Loopback withholds MAC transmissions from the fabric, returns them to MAC.
// - Autoneg off: bit 13 selects speed, 0 is 10 Mbps, 1 is 100/200.
// - Autoneg enable resets to one; negotiated results override speed and duplex.
// - Power-down bit has no effect; upper speed bit reads zero.
// - Isolate in PHY mode: outputs undriven, pulls off, inputs ignored.
// - In MAC mode the isolate bit has no effect on pins.
// - Isolation never touches the serial management pins.
// - Restart bit recomputes emulated negotiation results and self-clears.
// - Autoneg off: bit 8 selects duplex, 0 half, 1 full.
// - Collision test raises collision toward the MAC while it transmits.
// - Bits 31 to 16 are read-only zero padding.
// - Serial access carries only the lower 16 bits.
// - Serial frames answered only when the PHY address matches the strap.
`timescale 1ns/100ps
module virtual_phy_basic_control
    import vphy_ctl_pkg::*;
#(
    parameter int ADDR_W = 12
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic mm_wr_en,
    input wire logic mm_rd_en,
    input wire logic [ADDR_W-1:0] mm_addr,
    input wire logic [31:0] mm_wdata,
    output logic [31:0] mm_rdata_reg,
    output logic mm_rd_valid_reg,
    input wire logic load_valid,
    input wire logic [15:0] load_data,
    input wire logic [4:0] phy_addr_strap,
    input wire logic port_mac_mode,
    input wire logic lp_ability_100,
    input wire logic lp_ability_full,
    input wire logic mdc_pin,
    input wire logic mdio_in,
    output logic mdio_out_reg,
    output logic mdio_oe_reg,
    input wire logic mac_tx_en,
    input wire logic [3:0] mac_txd,
    output mii_beat_t mii_rx_reg,
    output logic mii_col_reg,
    output logic mii_crs_reg,
    output logic mii_out_oe_reg,
    output logic mii_pull_en_reg,
    output mii_beat_t fabric_tx_reg,
    input mii_beat_t fabric_rx,
    output logic speed_100_reg,
    output logic full_duplex_reg
);
    typedef enum logic [2:0] {MD_IDLE, MD_HDR, MD_TA, MD_WDATA, MD_RDATA} md_state_t;

    // Visible value of the control word: strobes, upper speed bit and reserved bits read zero
    function automatic logic [15:0] read_view(input ctl_word_t c);
        read_view = c & CTL_WRITE_MASK;
    endfunction : read_view

    logic [6:0] pins_s;
    logic mdc_s;
    logic mdio_s;
    mii_beat_t tx_s;
    pin_sync #(.WIDTH(7)) u_sync (
        .clk(clk),
        .rst(rst),
        .ce(ce),
        .din({mdc_pin, mdio_in, mac_tx_en, mac_txd}),
        .dout(pins_s)
    );
    assign mdc_s = pins_s[6];
    assign mdio_s = pins_s[5];
    assign tx_s = pins_s[4:0];

    ctl_word_t ctl_reg, ctl_next;
    logic an_speed_reg, an_speed_next;
    logic an_duplex_reg, an_duplex_next;
    logic an_pending_reg;
    logic [4:0] strap_reg;
    logic mm_hit;
    logic mdio_wr;
    logic [15:0] mdio_wdata;
    logic word_valid;
    ctl_word_t word_in;
    logic recompute;
    logic [15:0] load_masked;

    assign mm_hit = mm_addr == ADDR_W'(CTL_OFFSET);
    assign load_masked = load_data & CTL_WRITE_MASK;

    // Loader has priority over software, memory-mapped over serial writes
    always_comb begin
        word_valid = 1'b1;
        if (load_valid) begin
            word_in = load_data;
        end else if (mm_wr_en && mm_hit) begin
            word_in = mm_wdata[15:0];
        end else if (mdio_wr) begin
            word_in = mdio_wdata;
        end else begin
            word_in = '0;
            word_valid = 1'b0;
        end
    end

    // Control word update; soft reset returns defaults and also reruns negotiation
    always_comb begin
        ctl_next = ctl_reg;
        recompute = an_pending_reg;
        if (word_valid) begin
            if (word_in.vphy_soft_reset) begin
                ctl_next = CTL_DEFAULT;
                recompute = 1'b1;
            end else begin
                ctl_next = word_in & CTL_WRITE_MASK;
                recompute = recompute | word_in.vphy_autoneg_restart;
            end
        end
        an_speed_next = recompute ? lp_ability_100 : an_speed_reg;
        an_duplex_next = recompute ? lp_ability_full : an_duplex_reg;
    end

    // Negotiation rerun is deferred one cycle after reset so no port feeds the reset value
    always_ff @(posedge clk) begin
        if (rst) begin
            ctl_reg <= CTL_DEFAULT;
            an_speed_reg <= 1'b0;
            an_duplex_reg <= 1'b0;
            an_pending_reg <= 1'b1;
        end else if (ce) begin
            ctl_reg <= ctl_next;
            an_speed_reg <= an_speed_next;
            an_duplex_reg <= an_duplex_next;
            an_pending_reg <= 1'b0;
        end
    end

    // Strap caught on the first enabled edge after release
    logic strap_taken_reg;
    always_ff @(posedge clk) begin
        if (rst) begin
            strap_taken_reg <= 1'b0;
        end else if (ce && !strap_taken_reg) begin
            strap_reg <= phy_addr_strap;
            strap_taken_reg <= 1'b1;
        end
    end

    // Memory-mapped read answers one cycle later; unmapped addresses read zero
    always_ff @(posedge clk) begin
        if (rst) begin
            mm_rdata_reg <= 32'h0000_0000;
            mm_rd_valid_reg <= 1'b0;
        end else if (ce) begin
            mm_rd_valid_reg <= mm_rd_en;
            mm_rdata_reg <= (mm_rd_en && mm_hit) ? {HALF_ZERO, read_view(ctl_reg)} : '0;
        end
    end

    // Serial management slave, sampling on rising edges of the synchronised clock
    md_state_t md_state_reg, md_state_next;
    logic [5:0] md_cnt_reg, md_cnt_next;
    logic [15:0] md_shift_reg, md_shift_next;
    logic md_read_reg, md_read_next;
    logic md_hit_reg, md_hit_next;
    logic mdc_last_reg;
    logic mdio_out_next, mdio_oe_next;
    logic md_edge;
    mgmt_hdr_t hdr;

    assign md_edge = mdc_s && !mdc_last_reg;
    assign hdr = {md_shift_reg[11:0], mdio_s};
    assign mdio_wdata = {md_shift_reg[14:0], mdio_s};

    // Isolation has no say here, so management stays reachable while isolated
    always_comb begin
        md_state_next = md_state_reg;
        md_cnt_next = md_cnt_reg;
        md_shift_next = md_shift_reg;
        md_read_next = md_read_reg;
        md_hit_next = md_hit_reg;
        mdio_out_next = mdio_out_reg;
        mdio_oe_next = mdio_oe_reg;
        mdio_wr = 1'b0;
        if (md_edge) begin
            case (md_state_reg)
                MD_IDLE: begin
                    if (mdio_s) begin
                        md_cnt_next = (md_cnt_reg == PREAMBLE_ONES) ? md_cnt_reg : md_cnt_reg + 6'h01;
                    end else begin
                        // A zero after a full preamble is the first start bit
                        md_state_next = (md_cnt_reg == PREAMBLE_ONES) ? MD_HDR : MD_IDLE;
                        md_cnt_next = '0;
                    end
                end
                MD_HDR: begin
                    md_shift_next = {md_shift_reg[14:0], mdio_s};
                    md_cnt_next = md_cnt_reg + 6'h01;
                    if (md_cnt_reg == HDR_LAST) begin
                        md_cnt_next = '0;
                        md_read_next = hdr.opcode == OP_READ;
                        md_hit_next = hdr.reg_index == CTL_INDEX;
                        if (hdr.start_tail && hdr.phy_addr == strap_reg
                            && (hdr.opcode == OP_READ || hdr.opcode == OP_WRITE)) begin
                            md_state_next = MD_TA;
                        end else begin
                            md_state_next = MD_IDLE;
                        end
                    end
                end
                MD_TA: begin
                    md_cnt_next = md_cnt_reg + 6'h01;
                    if (md_cnt_reg == '0) begin
                        // Drive the second turnaround bit low on a hit read
                        mdio_oe_next = md_read_reg && md_hit_reg;
                        mdio_out_next = 1'b0;
                    end else begin
                        md_cnt_next = '0;
                        md_shift_next = read_view(ctl_reg);
                        mdio_out_next = ctl_reg.vphy_soft_reset & CTL_WRITE_MASK[15];
                        md_state_next = md_read_reg ? MD_RDATA : MD_WDATA;
                    end
                end
                MD_RDATA: begin
                    md_shift_next = {md_shift_reg[14:0], 1'b0};
                    mdio_out_next = md_shift_reg[14];
                    md_cnt_next = md_cnt_reg + 6'h01;
                    if (md_cnt_reg == DATA_LAST) begin
                        mdio_oe_next = 1'b0;
                        md_cnt_next = '0;
                        md_state_next = MD_IDLE;
                    end
                end
                MD_WDATA: begin
                    md_shift_next = {md_shift_reg[14:0], mdio_s};
                    md_cnt_next = md_cnt_reg + 6'h01;
                    if (md_cnt_reg == DATA_LAST) begin
                        mdio_wr = md_hit_reg;
                        md_cnt_next = '0;
                        md_state_next = MD_IDLE;
                    end
                end
                default: begin
                    md_state_next = MD_IDLE;
                    mdio_oe_next = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            md_state_reg <= MD_IDLE;
            md_cnt_reg <= '0;
            md_shift_reg <= '0;
            md_read_reg <= 1'b0;
            md_hit_reg <= 1'b0;
            mdc_last_reg <= 1'b0;
            mdio_out_reg <= 1'b0;
            mdio_oe_reg <= 1'b0;
        end else if (ce) begin
            md_state_reg <= md_state_next;
            md_cnt_reg <= md_cnt_next;
            md_shift_reg <= md_shift_next;
            md_read_reg <= md_read_next;
            md_hit_reg <= md_hit_next;
            mdc_last_reg <= mdc_s;
            mdio_out_reg <= mdio_out_next;
            mdio_oe_reg <= mdio_oe_next;
        end
    end

    // Port data path; power-down bit is deliberately not read here, only returned by register reads
    logic iso_active;
    mii_beat_t tx_eff;
    mii_beat_t rx_next;
    mii_beat_t fab_next;
    assign iso_active = ctl_reg.vphy_pin_isolate && !port_mac_mode;
    assign tx_eff = iso_active ? '0 : tx_s;

    always_comb begin
        rx_next = ctl_reg.vphy_loop_enable ? tx_eff : fabric_rx;
        fab_next = ctl_reg.vphy_loop_enable ? '0 : tx_eff;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            mii_rx_reg <= '0;
            fabric_tx_reg <= '0;
            mii_col_reg <= 1'b0;
            mii_crs_reg <= 1'b0;
            mii_out_oe_reg <= 1'b1;
            mii_pull_en_reg <= 1'b1;
            speed_100_reg <= 1'b0;
            full_duplex_reg <= 1'b0;
        end else if (ce) begin
            mii_rx_reg <= rx_next;
            fabric_tx_reg <= fab_next;
            mii_col_reg <= ctl_reg.vphy_collision_test && tx_eff.valid;
            mii_crs_reg <= tx_eff.valid || rx_next.valid;
            mii_out_oe_reg <= !iso_active;
            mii_pull_en_reg <= !iso_active;
            speed_100_reg <= ctl_reg.vphy_autoneg_enable ? an_speed_reg
                                                         : ctl_reg.vphy_speed_low_bit;
            full_duplex_reg <= ctl_reg.vphy_autoneg_enable ? an_duplex_reg
                                                           : ctl_reg.vphy_full_duplex;
        end
    end

    // Checks on the behaviour above
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    soft_reset_a: assert property (
        ce && word_valid && word_in.vphy_soft_reset |=> ctl_reg == CTL_DEFAULT && an_speed_reg == $past(lp_ability_100))
        else $error("soft reset did not restore defaults");
    loader_a: assert property (
        ce && load_valid && !load_data[15] |=> ctl_reg == $past(load_masked))
        else $error("loader word not taken");
    an_default_a: assert property (
        @(posedge clk) disable iff (1'b0) rst ##1 !rst |-> ctl_reg.vphy_autoneg_enable)
        else $error("autoneg enable not one after reset");
    loop_block_a: assert property (
        ce && ctl_reg.vphy_loop_enable |=> !fabric_tx_reg.valid && mii_rx_reg == $past(tx_eff))
        else $error("loopback frame leaked to fabric");
    forced_speed_a: assert property (
        ce && !ctl_reg.vphy_autoneg_enable |=>
            speed_100_reg == $past(ctl_reg.vphy_speed_low_bit)
            && full_duplex_reg == $past(ctl_reg.vphy_full_duplex))
        else $error("forced speed or duplex wrong");
    restart_a: assert property (
        ce && word_valid && !load_valid && word_in.vphy_autoneg_restart && !word_in.vphy_soft_reset
        |=> an_duplex_reg == $past(lp_ability_full) && !ctl_reg.vphy_autoneg_restart)
        else $error("restart did not recompute results");
    isolate_a: assert property (
        ce |=> mii_out_oe_reg == !($past(ctl_reg.vphy_pin_isolate) && !$past(port_mac_mode)))
        else $error("isolate output enable wrong");
    collision_a: assert property (
        ce && ctl_reg.vphy_collision_test && tx_eff.valid |=> mii_col_reg)
        else $error("collision test not raised");
    addr_filter_a: assert property (
        ce && md_edge && md_state_reg == MD_HDR && md_cnt_reg == HDR_LAST
        && hdr.phy_addr != strap_reg |=> md_state_reg == MD_IDLE ##1 !mdio_oe_reg)
        else $error("frame for another address answered");
    read_pad_a: assert property (
        mm_rd_valid_reg |-> mm_rdata_reg[31:16] == HALF_ZERO && (mm_rdata_reg[15:0] & ~CTL_WRITE_MASK) == HALF_ZERO)
        else $error("reserved bits read nonzero");

    loop_cov_c: cover property (ce && ctl_reg.vphy_loop_enable && tx_eff.valid);
    col_cov_c: cover property (mii_col_reg && ctl_reg.vphy_loop_enable);
    mdio_write_c: cover property (mdio_wr);
    mdio_read_c: cover property (md_state_reg == MD_RDATA && mdio_oe_reg);
endmodule : virtual_phy_basic_control

// ==== rtl/vphy_ctl_pkg.sv ====
// Shared constants, field layout and carrier types for the virtual PHY basic control block
package vphy_ctl_pkg;

    // Memory-mapped byte address of the control word
    localparam logic [11:0] CTL_OFFSET = 12'h1C0;
    // Serial register index of the control word
    localparam logic [4:0] CTL_INDEX = 5'h00;
    localparam logic [15:0] CTL_DEFAULT = 16'h1000;
    // Bits that software may store; soft reset and restart act as strobes only
    localparam logic [15:0] CTL_WRITE_MASK = 16'h7D80;
    localparam logic [15:0] HALF_ZERO = 16'h0000;

    // Serial management frame shape
    localparam logic [5:0] PREAMBLE_ONES = 6'h20;
    localparam logic [5:0] HDR_LAST = 6'h0C;
    localparam logic [5:0] DATA_LAST = 6'h0F;
    localparam logic [1:0] OP_READ = 2'h2;
    localparam logic [1:0] OP_WRITE = 2'h1;

    // Control word, most significant field first
    typedef struct packed {
        logic vphy_soft_reset;
        logic vphy_loop_enable;
        logic vphy_speed_low_bit;
        logic vphy_autoneg_enable;
        logic vphy_powerdown_unused;
        logic vphy_pin_isolate;
        logic vphy_autoneg_restart;
        logic vphy_full_duplex;
        logic vphy_collision_test;
        logic vphy_speed_high_bit;
        logic [5:0] reserved;
    } ctl_word_t;

    // Serial management frame header after the first start bit
    typedef struct packed {
        logic start_tail;
        logic [1:0] opcode;
        logic [4:0] phy_addr;
        logic [4:0] reg_index;
    } mgmt_hdr_t;

    // Nibble-wide MII data beat
    typedef struct packed {
        logic valid;
        logic [3:0] data;
    } mii_beat_t;

endpackage : vphy_ctl_pkg

// ==== sim/mac_host_model.sv ====
// Behavioural external MAC and serial management host facing the virtual PHY
`timescale 1ns/100ps
module mac_host_model (
    input wire logic clk,
    input wire logic mdio_out_reg,
    input wire logic mdio_oe_reg,
    output logic mdc_pin,
    output logic mdio_in,
    output logic mac_tx_en,
    output logic [3:0] mac_txd
);
    // Management clock half period in system clocks; well above the two the PHY needs
    localparam int HALF = 8;
    logic host_oe;
    logic host_val;

    // Shared data line with a pull-up: released line reads one
    assign mdio_in = host_oe ? host_val : (mdio_oe_reg ? mdio_out_reg : 1'b1);

    initial begin
        mdc_pin = 1'b0;
        host_oe = 1'b1;
        host_val = 1'b1;
        mac_tx_en = 1'b0;
        mac_txd = 4'h0;
    end

    // Transmit pins change just after a falling edge
    task automatic mac_set(input logic en, input logic [3:0] d);
        @(negedge clk);
        mac_tx_en = en;
        mac_txd = d;
    endtask : mac_set

    // One management clock period with the host driving a bit
    task automatic send_bit(input logic b);
        mdc_pin = 1'b0;
        host_oe = 1'b1;
        host_val = b;
        repeat (HALF) @(negedge clk);
        mdc_pin = 1'b1;
        repeat (HALF) @(negedge clk);
    endtask : send_bit

    // Full frame; on a read, rd holds the second turnaround bit then 16 data bits
    task automatic frame(input logic [1:0] op, input logic [4:0] pa, input logic [15:0] wd,
                         output logic [16:0] rd);
        logic [31:0] hdr;
        hdr = {2'b01, op, pa, 5'h00, 2'b10, wd};
        rd = 17'h00000;
        repeat (32) send_bit(1'b1);
        for (int i = 31; i >= 18; i--) begin
            send_bit(hdr[i]);
        end
        if (op == 2'b01) begin
            for (int i = 17; i >= 0; i--) begin
                send_bit(hdr[i]);
            end
        end else begin
            // Release for turnaround and sample just before each rising edge
            host_oe = 1'b0;
            mdc_pin = 1'b0;
            repeat (HALF) @(negedge clk);
            mdc_pin = 1'b1;
            repeat (HALF) @(negedge clk);
            for (int i = 16; i >= 0; i--) begin
                mdc_pin = 1'b0;
                repeat (HALF) @(negedge clk);
                rd[i] = mdio_in;
                mdc_pin = 1'b1;
                repeat (HALF) @(negedge clk);
            end
        end
        // Clock stands still low between frames
        mdc_pin = 1'b0;
        host_oe = 1'b1;
        host_val = 1'b1;
    endtask : frame
endmodule : mac_host_model

// ==== sim/tb_virtual_phy_basic_control.sv ====
// Self-checking bench for the virtual PHY basic control register
`timescale 1ns/100ps
module tb_virtual_phy_basic_control;
    import vphy_ctl_pkg::*;
    localparam logic [4:0] STRAP = 5'h05;
    localparam logic [11:0] UNMAPPED = 12'h1C4;
    localparam int LIMIT = 30000;
    logic clk, rst, ce, mm_wr_en, mm_rd_en, load_valid, port_mac_mode;
    logic lp_ability_100, lp_ability_full, mdc_pin, mdio_in, mdio_out_reg, mdio_oe_reg;
    logic [11:0] mm_addr;
    logic [31:0] mm_wdata, mm_rdata_reg, rd;
    logic mm_rd_valid_reg, mac_tx_en, mii_col_reg, mii_crs_reg, mii_out_oe_reg;
    logic mii_pull_en_reg, speed_100_reg, full_duplex_reg;
    logic [15:0] load_data;
    logic [16:0] srd;
    logic [3:0] mac_txd;
    mii_beat_t mii_rx_reg, fabric_tx_reg, fabric_rx;
    int n_mismatch, compares;
    int cycles = 0;

    virtual_phy_basic_control DUT (.clk(clk), .rst(rst), .ce(ce), .mm_wr_en(mm_wr_en),
        .mm_rd_en(mm_rd_en), .mm_addr(mm_addr), .mm_wdata(mm_wdata),
        .mm_rdata_reg(mm_rdata_reg), .mm_rd_valid_reg(mm_rd_valid_reg),
        .load_valid(load_valid), .load_data(load_data), .phy_addr_strap(STRAP),
        .port_mac_mode(port_mac_mode), .lp_ability_100(lp_ability_100),
        .lp_ability_full(lp_ability_full), .mdc_pin(mdc_pin), .mdio_in(mdio_in),
        .mdio_out_reg(mdio_out_reg), .mdio_oe_reg(mdio_oe_reg), .mac_tx_en(mac_tx_en),
        .mac_txd(mac_txd), .mii_rx_reg(mii_rx_reg), .mii_col_reg(mii_col_reg),
        .mii_crs_reg(mii_crs_reg), .mii_out_oe_reg(mii_out_oe_reg),
        .mii_pull_en_reg(mii_pull_en_reg), .fabric_tx_reg(fabric_tx_reg),
        .fabric_rx(fabric_rx), .speed_100_reg(speed_100_reg),
        .full_duplex_reg(full_duplex_reg));

    mac_host_model MAC (.clk(clk), .mdio_out_reg(mdio_out_reg), .mdio_oe_reg(mdio_oe_reg),
        .mdc_pin(mdc_pin), .mdio_in(mdio_in), .mac_tx_en(mac_tx_en), .mac_txd(mac_txd));

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    // Hang guard: a runaway run counts as a mismatch
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == LIMIT) begin
            n_mismatch = n_mismatch + 1;
            end_of_test();
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares = compares + 1;
        if (seen !== exp) begin
            n_mismatch = n_mismatch + 1;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic tick(input int n);
        repeat (n) @(negedge clk);
    endtask : tick

    // Write is taken at the rising edge between two falling edges
    task automatic mm_write(input logic [11:0] a, input logic [31:0] d);
        mm_wr_en = 1'b1;
        mm_addr = a;
        mm_wdata = d;
        tick(1);
        mm_wr_en = 1'b0;
        tick(1);
    endtask : mm_write

    // Answer stands for one cycle after the taking edge
    task automatic mm_read(input logic [11:0] a, output logic [31:0] d);
        mm_rd_en = 1'b1;
        mm_addr = a;
        tick(1);
        mm_rd_en = 1'b0;
        check({31'h0, mm_rd_valid_reg}, 32'h00000001);
        d = mm_rdata_reg;
    endtask : mm_read

    task automatic expect_ctl(input logic [31:0] exp);
        logic [31:0] v;
        mm_read(CTL_OFFSET, v);
        check(v, exp);
    endtask : expect_ctl

    task automatic expect_mode(input logic s, input logic d);
        tick(3);
        check({30'h0, speed_100_reg, full_duplex_reg}, {30'h0, s, d});
    endtask : expect_mode

    task automatic test_done(input string name);
        $display("Test %s finished", name);
    endtask : test_done

    task automatic end_of_test();
        $display("Comparisons %0d, mismatches %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : end_of_test

    initial begin
        {n_mismatch, compares} = 0;
        {rst, ce} = 2'b11;
        {mm_wr_en, mm_rd_en, load_valid, port_mac_mode} = 4'h0;
        {lp_ability_100, lp_ability_full} = 2'b10;
        mm_addr = 12'h000;
        mm_wdata = 32'h00000000;
        load_data = 16'h0000;
        fabric_rx = 5'h1A;
        tick(5);
        rst = 1'b0;
        tick(2);
        expect_ctl(32'h00001000);
        expect_mode(1'b1, 1'b0);
        mm_read(UNMAPPED, rd);
        check(rd, 32'h00000000);
        check({30'h0, mii_out_oe_reg, mii_pull_en_reg}, 32'h00000003);
        test_done("reset");
        mm_write(CTL_OFFSET, 32'hFFFF7FFF);
        expect_ctl(32'h00007D80);
        test_done("mask");
        // Every forced speed and duplex pair, with power-down set to show it is inert
        for (int i = 0; i < 4; i++) begin
            mm_write(CTL_OFFSET, 32'h00000800 | (i[1] << 13) | (i[0] << 8));
            expect_mode(i[1], i[0]);
        end
        test_done("forced");
        {lp_ability_100, lp_ability_full} = 2'b01;
        mm_write(CTL_OFFSET, 32'h00002100);
        mm_write(CTL_OFFSET, 32'h00001000);
        expect_mode(1'b1, 1'b0);
        mm_write(CTL_OFFSET, 32'h00001200);
        expect_mode(1'b0, 1'b1);
        expect_ctl(32'h00001000);
        test_done("restart");
        load_data = 16'h4100;
        load_valid = 1'b1;
        tick(1);
        load_valid = 1'b0;
        expect_ctl(32'h00004100);
        load_data = 16'hC100;
        load_valid = 1'b1;
        tick(1);
        load_valid = 1'b0;
        expect_ctl(32'h00001000);
        test_done("loader");
        mm_write(CTL_OFFSET, 32'h00000000);
        MAC.mac_set(1'b1, 4'h9);
        tick(4);
        check({27'h0, fabric_tx_reg}, 32'h00000019);
        // Collision test is only used together with loopback
        mm_write(CTL_OFFSET, 32'h00004080);
        tick(3);
        check({27'h0, mii_rx_reg}, 32'h00000019);
        check({31'h0, fabric_tx_reg.valid}, 32'h00000000);
        check({31'h0, mii_col_reg}, 32'h00000001);
        MAC.mac_set(1'b0, 4'h0);
        tick(4);
        check({31'h0, mii_col_reg}, 32'h00000000);
        test_done("datapath");
        mm_write(CTL_OFFSET, 32'h00004400);
        MAC.mac_set(1'b1, 4'h9);
        tick(4);
        check({30'h0, mii_out_oe_reg, mii_pull_en_reg}, 32'h00000000);
        check({31'h0, mii_rx_reg.valid}, 32'h00000000);
        // Ignored transmit input and looped receive leave no carrier
        check({31'h0, mii_crs_reg}, 32'h00000000);
        port_mac_mode = 1'b1;
        tick(4);
        check({30'h0, mii_out_oe_reg, mii_pull_en_reg}, 32'h00000003);
        check({31'h0, mii_crs_reg}, 32'h00000001);
        check({27'h0, mii_rx_reg}, 32'h00000019);
        port_mac_mode = 1'b0;
        MAC.mac_set(1'b0, 4'h0);
        test_done("isolate");
        // Serial access still works while the port is isolated
        MAC.frame(OP_READ, STRAP, 16'h0000, srd);
        check({15'h0, srd}, 32'h00004400);
        MAC.frame(OP_READ, STRAP ^ 5'h01, 16'h0000, srd);
        check({15'h0, srd}, 32'h0001FFFF);
        MAC.frame(OP_WRITE, STRAP, 16'h0100, srd);
        tick(8);
        expect_ctl(32'h00000100);
        test_done("serial");
        {lp_ability_100, lp_ability_full} = 2'b11;
        mm_write(CTL_OFFSET, 32'h00008000);
        expect_ctl(32'h00001000);
        expect_mode(1'b1, 1'b1);
        mm_write(CTL_OFFSET, 32'h00004000);
        rst = 1'b1;
        tick(2);
        rst = 1'b0;
        tick(2);
        expect_ctl(32'h00001000);
        // A write while the clock enable is low must leave the word untouched
        ce = 1'b0;
        mm_write(CTL_OFFSET, 32'h00000000);
        ce = 1'b1;
        expect_ctl(32'h00001000);
        test_done("second_reset");
        end_of_test();
    end
endmodule : tb_virtual_phy_basic_control
